// >>> common/cor_pkg.sv
// Package for the counter output routing block: register map and types
`default_nettype none
package cor_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] SRC_OFF = 8'h04;
	localparam logic [7:0] PRESET_OFF = 8'h08;
	localparam logic [7:0] COUNT_OFF = 8'h0C;
	localparam logic [7:0] STAT_OFF = 8'h10;
	localparam logic [7:0] IRQ_STAT_OFF = 8'h14;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h18;
	localparam logic [7:0] OUTS_OFF = 8'h1C;
	// Control fields
	localparam int CTRL_WIDE_BIT = 0;
	localparam int CTRL_SIGNED_BIT = 1;
	localparam int CTRL_CLR_CNT_BIT = 2;
	localparam int CTRL_TRIG_EN_BIT = 3;
	// Link enable fields in SRC register
	localparam int SRC_OUT_DET_BIT = 0;
	localparam int SRC_OUT_LAT_BIT = 2;
	localparam int SRC_EV_DET_BIT = 4;
	localparam int SRC_EV_CMP_BIT = 8;
	// Interrupt status fields
	localparam int IRQ_COINC_BIT = 0;
	localparam int IRQ_LATCH_BIT = 1;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] SRC_RST = 32'h0000_0000;
	localparam logic [31:0] PRESET_RST = 32'h0000_0000;
	localparam logic [31:0] MASK_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Internal sources seen by the output stage
	typedef struct packed {
		logic [1:0] det;
		logic [1:0] cmp;
		logic pg;
		logic cam;
	} cor_src_t;

	// Outputs toward pins and neighbours
	typedef struct packed {
		logic out0;
		logic [3:0] event_out;
		logic pg_out;
		logic cam_out;
		logic trig;
	} cor_out_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_RESP = 2'b01
	} cor_rd_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} cor_wr_t;
endpackage
`default_nettype wire

// >>> rtl/cor_top.sv
// Counter output routing: latches, pin merge, coincidence, AXI4-Lite regs
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE_01] Latch gives fixed high or low, feeds output
// [RULE_02] Set raises latch, holds until clear
// [RULE_03] Simultaneous set and clear: clear wins
// [RULE_04] Output pin is OR of linked sources
// [RULE_05] Four event outputs narrow, two wide
// [RULE_06] Each event pin ORs its linked sources
// [RULE_07] Events 0,1 compare 0; 2,3 compare 1
// [RULE_08] Events 0,1 detect 0; 2,3 detect 1
// [RULE_09] Wide mode: event terminals take no links
// [RULE_10] Pattern output only in narrow unsigned
// [RULE_11] Cam output only in wide mode
// [RULE_12] Counter adds one per count-up high
// [RULE_13] Range compare, both bounds equal preset
// [RULE_14] Compare output high at coincidence
// [RULE_15] Coincidence pulses output 0, raises interrupt
// [RULE_16] Coincidence optionally triggers other block
// [RULE_17] Wide mode uses cam unit for coincidence; code takes coincidence from the counter/preset compare in both modes
// [RULE_18] Configurer picks fastest counting clock
// [RULE_19] Outputs registered, one cycle after source
module cor_top #(
	parameter int CNT_W = 32
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire cor_pkg::cor_src_t src_in,
	input wire logic count_up,
	input wire logic [1:0] latch_set,
	input wire logic [1:0] latch_clr,
	output var cor_pkg::cor_out_t pins,
	output logic irq,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import cor_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers (pins from outside)
	logic [1:0] up_sync_ff;
	logic [1:0] nxt_up_sync;
	always_comb begin
		nxt_up_sync = {up_sync_ff[0], count_up};
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			up_sync_ff <= 2'b00;
		end else begin
			up_sync_ff <= nxt_up_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0] ctrl_ff, src_ff, preset_ff, mask_ff;
	logic [31:0] nxt_ctrl, nxt_src, nxt_preset, nxt_mask;
	logic [1:0] istat_ff, nxt_istat;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [1:0] latch_ff, nxt_latch;
	logic coinc_ff, nxt_coinc;
	cor_out_t nxt_pins;
	logic nxt_irq;
	logic wide, uns;
	logic coinc_now, coinc_rise;
	logic [3:0] ev_raw;

	assign wide = ctrl_ff[CTRL_WIDE_BIT];
	assign uns = ~ctrl_ff[CTRL_SIGNED_BIT];

	////////////////////////////////////////////////////////////////////////
	// Counter and coincidence comparator
	always_comb begin
		nxt_cnt = cnt_ff;
		if (ctrl_ff[CTRL_CLR_CNT_BIT]) begin
			nxt_cnt = '0;
		end else if (up_sync_ff[1]) begin
			nxt_cnt = cnt_ff + CNT_W'(1); // RULE_12
		end
		// Both bounds equal preset, so range collapses to a match
		coinc_now = (cnt_ff >= preset_ff[CNT_W-1:0]) &&
			(cnt_ff <= preset_ff[CNT_W-1:0]); // RULE_13
		nxt_coinc = coinc_now; // RULE_14
		coinc_rise = coinc_now & ~coinc_ff;
	end

	////////////////////////////////////////////////////////////////////////
	// Set/reset latches; second exists only in narrow mode
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (latch_clr[i]) begin
				nxt_latch[i] = 1'b0; // RULE_03
			end else if (latch_set[i]) begin
				nxt_latch[i] = 1'b1; // RULE_02
			end else begin
				nxt_latch[i] = latch_ff[i]; // RULE_01
			end
		end
		if (wide) begin
			nxt_latch[1] = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output merge
	always_comb begin
		nxt_pins = '0;
		// Coincidence edge makes a one-cycle pulse on output 0
		nxt_pins.out0 = |(src_in.det & src_ff[SRC_OUT_DET_BIT +: 2]) |
			|(latch_ff & src_ff[SRC_OUT_LAT_BIT +: 2]) |
			coinc_rise; // RULE_04 RULE_15
		for (int e = 0; e < 4; e++) begin
			ev_raw[e] = (src_in.det[e/2] & src_ff[SRC_EV_DET_BIT + e]) |
				(src_in.cmp[e/2] & src_ff[SRC_EV_CMP_BIT + e]); // RULE_06 RULE_07 RULE_08
		end
		// Wide mode: two terminals, with no internal links
		if (wide) begin
			nxt_pins.event_out = 4'h0; // RULE_05 RULE_09
		end else begin
			nxt_pins.event_out = ev_raw; // RULE_05
		end
		nxt_pins.pg_out = !wide && uns && src_in.pg; // RULE_10
		nxt_pins.cam_out = wide && src_in.cam; // RULE_11 RULE_17
		nxt_pins.trig = ctrl_ff[CTRL_TRIG_EN_BIT] && coinc_rise; // RULE_16
		nxt_irq = |(istat_ff & mask_ff[1:0]);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= '0;
			// Count and preset both reset to zero: match already stands,
			// so no false coincidence edge follows reset
			coinc_ff <= 1'b1;
			latch_ff <= 2'b00;
			pins <= '0;
			irq <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			coinc_ff <= nxt_coinc;
			latch_ff <= nxt_latch;
			pins <= nxt_pins; // RULE_19
			irq <= nxt_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: takes address and data in either order
	logic aw_hold_ff, w_hold_ff, nxt_aw_hold, nxt_w_hold;
	logic [7:0] wa_ff, nxt_wa;
	logic [31:0] wd_ff, nxt_wd;
	logic [3:0] ws_ff, nxt_ws;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic do_wr, wr_hit;
	logic [31:0] wmask;

	// Read path
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	logic rd_take, rd_istat;

	always_comb begin
		nxt_aw_hold = aw_hold_ff;
		nxt_w_hold = w_hold_ff;
		nxt_wa = wa_ff;
		nxt_wd = wd_ff;
		nxt_ws = ws_ff;
		if (s_axi_awvalid && !aw_hold_ff) begin
			nxt_aw_hold = 1'b1;
			nxt_wa = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !w_hold_ff) begin
			nxt_w_hold = 1'b1;
			nxt_wd = s_axi_wdata;
			nxt_ws = s_axi_wstrb;
		end
		do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		wr_hit = (wa_ff == CTRL_OFF) || (wa_ff == SRC_OFF) ||
			(wa_ff == PRESET_OFF) || (wa_ff == IRQ_MASK_OFF);
		if (do_wr) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{ws_ff[b]}};
		end
		nxt_ctrl = ctrl_ff;
		nxt_src = src_ff;
		nxt_preset = preset_ff;
		nxt_mask = mask_ff;
		if (do_wr) begin
			case (wa_ff)
				CTRL_OFF: nxt_ctrl = (ctrl_ff & ~wmask) | (wd_ff & wmask);
				SRC_OFF: nxt_src = (src_ff & ~wmask) | (wd_ff & wmask);
				PRESET_OFF: nxt_preset = (preset_ff & ~wmask) | (wd_ff & wmask);
				IRQ_MASK_OFF: nxt_mask = (mask_ff & ~wmask) | (wd_ff & wmask);
				default: nxt_ctrl = ctrl_ff;
			endcase
		end
		// Self-clearing counter reset
		if (ctrl_ff[CTRL_CLR_CNT_BIT]) begin
			nxt_ctrl[CTRL_CLR_CNT_BIT] = 1'b0;
		end
	end

	always_comb begin
		rd_take = s_axi_arvalid && !rvalid_ff;
		rd_istat = rd_take && (s_axi_araddr[7:0] == IRQ_STAT_OFF);
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		if (rd_take) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = RESP_OKAY;
			case (s_axi_araddr[7:0])
				CTRL_OFF: nxt_rdata = ctrl_ff;
				SRC_OFF: nxt_rdata = src_ff;
				PRESET_OFF: nxt_rdata = preset_ff;
				COUNT_OFF: nxt_rdata = 32'(cnt_ff);
				STAT_OFF: nxt_rdata = {28'h000_0000, coinc_ff, latch_ff, irq};
				IRQ_STAT_OFF: nxt_rdata = {30'h0, istat_ff};
				IRQ_MASK_OFF: nxt_rdata = mask_ff;
				OUTS_OFF: nxt_rdata = {24'h00_0000, pins};
				default: begin
					nxt_rdata = 32'h0000_0000;
					nxt_rresp = RESP_SLVERR;
				end
			endcase
		end
		// Read clears status; a new event in the same cycle survives
		nxt_istat = rd_istat ? 2'b00 : istat_ff;
		if (coinc_rise) begin
			nxt_istat[IRQ_COINC_BIT] = 1'b1; // RULE_15
		end
		if (|(nxt_latch & ~latch_ff)) begin
			nxt_istat[IRQ_LATCH_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			wa_ff <= 8'h00;
			wd_ff <= 32'h0000_0000;
			ws_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			ctrl_ff <= CTRL_RST;
			src_ff <= SRC_RST;
			preset_ff <= PRESET_RST;
			mask_ff <= MASK_RST;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
			istat_ff <= 2'b00;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			wa_ff <= nxt_wa;
			wd_ff <= nxt_wd;
			ws_ff <= nxt_ws;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			ctrl_ff <= nxt_ctrl;
			src_ff <= nxt_src;
			preset_ff <= nxt_preset;
			mask_ff <= nxt_mask;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			istat_ff <= nxt_istat;
		end
	end

	// Ready is high while the holding slot is free
	assign s_axi_awready = !aw_hold_ff;
	assign s_axi_wready = !w_hold_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule
`default_nettype wire

// >>> dv/cor_peer.sv
// Neighbour counter block model: counts trigger pulses received
`timescale 1ns/1ps
`default_nettype none
module cor_peer (
	input wire logic clock,
	input wire logic arst_n,
	input wire cor_pkg::cor_out_t pins,
	output var int trig_cnt
);
	import cor_pkg::*;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			trig_cnt <= 0;
		else if (pins.trig)
			trig_cnt <= trig_cnt + 1;
	end
endmodule
`default_nettype wire

// >>> dv/cor_top_sva.sv
// Checker for output routing pins and write response
`timescale 1ns/1ps
`default_nettype none
module cor_top_sva (
	input wire logic clock,
	input wire logic arst_n,
	input wire cor_pkg::cor_src_t src_in,
	input wire cor_pkg::cor_out_t pins,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	import cor_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	////////////////
	property p_excl; !(pins.pg_out && pins.cam_out); endproperty
	a_excl: assert property (p_excl)
		else $error("pg and cam out both high");
	property p_pg; pins.pg_out |-> $past(src_in.pg); endproperty
	a_pg: assert property (p_pg)
		else $error("pg out without source");
	property p_cam; pins.cam_out |-> $past(src_in.cam); endproperty
	a_cam: assert property (p_cam)
		else $error("cam out without source");
	property p_ev;
		|pins.event_out |-> $past(|{src_in.det, src_in.cmp});
	endproperty
	a_ev: assert property (p_ev)
		else $error("event out without source");
	property p_wide; pins.cam_out |-> pins.event_out == 4'h0; endproperty
	a_wide: assert property (p_wide)
		else $error("event out in wide mode");
	property p_trig; pins.trig |=> !pins.trig [*3]; endproperty
	a_trig: assert property (p_trig)
		else $error("trigger not a single pulse");
	property p_tout; pins.trig |-> pins.out0; endproperty
	a_tout: assert property (p_tout)
		else $error("coincidence pulse missing on out0");
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bdone: assert property (p_bdone)
		else $error("write response repeated");
	////////////////
	c_trig: cover property (pins.trig);
	c_cam: cover property (pins.cam_out);
	c_ev: cover property (pins.event_out[3]);
endmodule
bind cor_top cor_top_sva cor_top_sva_i (.clock(clock), .arst_n(arst_n),
	.src_in(src_in), .pins(pins), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready));
`default_nettype wire

// >>> dv/cor_top_tb.sv
// Self-checking testbench for the counter output routing block
`timescale 1ns/1ps
`default_nettype none
module cor_top_tb;
	import cor_pkg::*;
	logic clock, arst_n, count_up, irq, awv, awr, wv, wr_, bv, bw;
	logic arv, arr, rv, rw;
	logic [1:0] latch_set, latch_clr, resp, br, rr;
	logic [31:0] awa, wd, ara, rd, got, r;
	logic [3:0] ev, ws;
	cor_src_t src_in;
	cor_out_t pins;
	int failures, n_compared, trig_cnt;
	logic [31:0] rng = 32'h74d9_f83e;
	logic [7:0] offs [5] = '{CTRL_OFF, SRC_OFF, PRESET_OFF, COUNT_OFF,
		IRQ_MASK_OFF};
	cor_top cor_top_i (.clock(clock), .arst_n(arst_n), .src_in(src_in),
		.count_up(count_up), .latch_set(latch_set), .latch_clr(latch_clr),
		.pins(pins), .irq(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bw), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rw));
	cor_peer cor_peer_i (.clock(clock), .arst_n(arst_n), .pins(pins),
		.trig_cnt(trig_cnt));
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	function logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	////////////////
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic done, ta, tw;
		done = 0;
		awa <= {24'h0, a};
		wd <= d;
		awv <= 1;
		wv <= 1;
		while (!done) begin
			@(negedge clock);
			ta = awv && awr;
			tw = wv && wr_;
			done = bv;
			resp = br;
			@(posedge clock);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
		end
	endtask
	task rdr(input logic [7:0] a, output logic [31:0] d);
		logic done, ta;
		done = 0;
		ara <= {24'h0, a};
		arv <= 1;
		while (!done) begin
			@(negedge clock);
			ta = arv && arr;
			done = rv;
			d = rd;
			resp = rr;
			@(posedge clock);
			if (ta) arv <= 0;
		end
	endtask
	task lstep(input logic [1:0] s, input logic [1:0] c, input logic e);
		latch_set <= s;
		latch_clr <= c;
		@(posedge clock);
		latch_set <= 0;
		latch_clr <= 0;
		repeat (3) @(posedge clock);
		@(negedge clock);
		chk("out0", 32'(e), 32'(pins.out0));
		@(posedge clock);
	endtask
	task give_verdict();
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////
	initial begin
		#200us;
		failures++;
		give_verdict();
	end
	initial begin
		arst_n = 0;
		{count_up, latch_set, latch_clr, awv, wv, arv, awa, wd, ara} = '0;
		src_in = '0;
		ws = 4'hF;
		bw = 1;
		rw = 1;
		repeat (5) @(posedge clock);
		arst_n <= 1;
		@(posedge clock);
		foreach (offs[i]) begin
			rdr(offs[i], got);
			chk("reset value", 0, got);
		end
		rdr(8'h40, got);
		chk("unmapped resp", 32'(RESP_SLVERR), 32'(resp));
		wr(COUNT_OFF, 1);
		chk("ro write resp", 32'(RESP_SLVERR), 32'(resp));
		wr(SRC_OFF, 32'h0000_0FF3);
		for (int m = 0; m < 3; m++) begin
			wr(CTRL_OFF, m);
			repeat (12) begin
				r = xs();
				src_in <= r[5:0];
				@(posedge clock);
				@(negedge clock);
				for (int e = 0; e < 4; e++)
					ev[e] = (src_in.det[e/2] | src_in.cmp[e/2]) & (m != 1);
				chk("event", 32'(ev), 32'(pins.event_out));
				chk("pg", 32'(src_in.pg & (m == 0)), 32'(pins.pg_out));
				chk("cam", 32'(src_in.cam & (m == 1)), 32'(pins.cam_out));
				chk("out0", 32'(|src_in.det), 32'(pins.out0));
				@(posedge clock);
			end
		end
		wr(CTRL_OFF, 0);
		wr(SRC_OFF, 32'h0000_000C);
		src_in <= '0;
		lstep(2'b01, 2'b00, 1);
		lstep(2'b00, 2'b00, 1);
		lstep(2'b11, 2'b01, 1);
		rdr(STAT_OFF, got);
		chk("latch state", 32'h0000_0004, got & 32'h0000_0006);
		lstep(2'b00, 2'b10, 0);
		rdr(IRQ_STAT_OFF, got);
		rdr(IRQ_STAT_OFF, got);
		chk("irq stat cleared", 0, got);
		wr(PRESET_OFF, 5);
		wr(CTRL_OFF, 32'h0000_000C);
		count_up <= 1;
		repeat (5) @(posedge clock);
		count_up <= 0;
		repeat (6) @(posedge clock);
		rdr(COUNT_OFF, got);
		chk("count", 5, got);
		rdr(STAT_OFF, got);
		chk("coinc flag", 32'h0000_0008, got & 32'h0000_0008);
		@(negedge clock);
		chk("trigger count", 1, trig_cnt);
		chk("irq masked", 0, 32'(irq));
		@(posedge clock);
		wr(IRQ_MASK_OFF, 1);
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("irq", 1, 32'(irq));
		@(posedge clock);
		rdr(IRQ_STAT_OFF, got);
		chk("irq stat", 1, got);
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("irq after clear", 0, 32'(irq));
		@(posedge clock);
		// Only byte lane 1 written: low byte of preset must survive
		ws <= 4'h2;
		wr(PRESET_OFF, 32'h0000_0707);
		ws <= 4'hF;
		rdr(PRESET_OFF, got);
		chk("strobed preset", 32'h0000_0705, got);
		give_verdict();
	end
endmodule
`default_nettype wire
